// file: verilog/ebha_defs.vh
// Constants shared by the external bus hold arbiter files.
`ifndef EBHA_DEFS_VH
`define EBHA_DEFS_VH
`define EBHA_SZ_BYTE 2'h0
`define EBHA_SZ_HALF 2'h1
`define EBHA_SZ_WORD 2'h2
`define EBHA_BUS8 1'h1
`define EBHA_ST_RESET 3'h0
`define EBHA_ST_IDLE 3'h1
`define EBHA_ST_BUSY 3'h2
`define EBHA_ST_FLOAT 3'h3
`define EBHA_ST_HOLD 3'h4
`define EBHA_ST_GAP 3'h5
`define EBHA_REQ_FETCH 3'h0
`define EBHA_REQ_OPER 3'h1
`define EBHA_REQ_DMA 3'h2
`define EBHA_REQ_REFR 3'h3
`define EBHA_REQ_NONE 3'h7
`define EBHA_SYNC_STAGES 2
`endif

// file: verilog/ebha_split.v
// Splits one operand access into its sequence of bus pieces.
`timescale 1ns/1ns
`default_nettype none
`include "ebha_defs.vh"
module ebha_split (
   input wire i_bus8,
   input wire [1:0] i_size,
   input wire [1:0] i_addr_low,
   output reg [2:0] o_pieces,
   output reg [5:0] o_piece_sizes
);
   // Piece sizes are packed two bits each, first piece in the low bits.
   always @* begin
      o_pieces = 3'h1;
      o_piece_sizes = {4'h0, i_size};
      if (i_bus8) begin
         if (i_size == `EBHA_SZ_WORD) begin
            o_pieces = 3'h4;
            o_piece_sizes = 6'h00;
         end else if (i_size == `EBHA_SZ_HALF) begin
            o_pieces = 3'h2;
            o_piece_sizes = 6'h00;
         end
      end else if (i_size == `EBHA_SZ_HALF && i_addr_low[0]) begin
         o_pieces = 3'h2;
         o_piece_sizes = 6'h00;
      end else if (i_size == `EBHA_SZ_WORD) begin
         if (i_addr_low[0]) begin
            o_pieces = 3'h3;
            o_piece_sizes = {`EBHA_SZ_BYTE, `EBHA_SZ_HALF, `EBHA_SZ_BYTE};
         end else begin
            o_pieces = 3'h2;
            o_piece_sizes = {2'h0, `EBHA_SZ_HALF, `EBHA_SZ_HALF};
         end
      end
   end
endmodule
`default_nettype wire

// file: verilog/ebha_arbiter.v
// External bus hold and priority arbiter.
`timescale 1ns/1ns
`default_nettype none
`include "ebha_defs.vh"
module ebha_arbiter (
   input wire i_core_clk,
   input wire i_nrst,
   input wire i_power_on_rst,
   input wire i_bus_hold_request_n,
   input wire i_port_pin_grant_function,
   input wire i_port_pin_request_function,
   input wire i_bus8,
   input wire i_cpu_bus_clk,
   input wire i_stop_idle_mode,
   input wire i_halt_mode,
   input wire i_refresh_req,
   input wire i_dma_req,
   input wire i_fetch_req,
   input wire i_oper_req,
   input wire [1:0] i_oper_size,
   input wire [1:0] i_oper_addr_low,
   input wire i_oper_rmw,
   input wire i_cycle_done,
   output wire o_bus_hold_grant_n,
   output wire o_bus_hold_grant_n_oe_n,
   output wire o_bus_float_n,
   output reg [2:0] o_owner,
   output reg [1:0] o_piece_size,
   output reg o_rmw_write,
   output wire o_cycle_start,
   output wire o_oper_ack,
   output wire o_ext_stall
);
   reg [1:0] req_sync_reg;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [2:0] piece_left_reg;
   reg [5:0] sizes_reg;
   reg rmw_pend_reg;
   reg grant_reg;
   reg float_reg;
   reg por_block_reg;
   wire warm_now;
   reg [2:0] pick;
   wire [2:0] pieces;
   wire [5:0] piece_sizes;
   wire hold_enabled;
   wire hold_req;
   wire locked;
   wire any_req;
   wire start;

   ebha_split u_split (
      .i_bus8(i_bus8),
      .i_size(i_oper_size),
      .i_addr_low(i_oper_addr_low),
      .o_pieces(pieces),
      .o_piece_sizes(piece_sizes)
   );

   // Pin synchroniser; only stage two feeds logic. It runs through reset so that
   // the request level held together with reset is known at the first edge after release.
   always @(posedge i_core_clk) begin
      req_sync_reg <= {req_sync_reg[0], i_bus_hold_request_n};
   end

   assign hold_enabled = i_port_pin_grant_function & i_port_pin_request_function;
   assign hold_req = hold_enabled & ~req_sync_reg[1] & ~i_stop_idle_mode
      & ~por_block_reg;
   assign warm_now = ~i_power_on_rst & hold_enabled & ~req_sync_reg[1];
   // Lock spans the gaps between split pieces and the read-to-write gap.
   assign locked = (piece_left_reg != 3'h0) | rmw_pend_reg;
   assign any_req = i_refresh_req | i_dma_req | i_fetch_req | i_oper_req | rmw_pend_reg;

   // Fixed priority among internal requesters, hold sitting above them all outside a locked sequence, where refresh and DMA still win slots.
   always @* begin
      pick = `EBHA_REQ_NONE;
      if (i_refresh_req) begin
         pick = `EBHA_REQ_REFR;
      end else if (i_dma_req) begin
         pick = `EBHA_REQ_DMA;
      end else if (i_fetch_req && (!locked || rmw_pend_reg || i_cpu_bus_clk)) begin
         pick = `EBHA_REQ_FETCH;
      end else if (i_oper_req || locked) begin
         pick = `EBHA_REQ_OPER;
      end
   end

   // A locked sequence restarts on cycle done, but refresh or DMA still gets that slot first.
   assign start = ((state_reg == `EBHA_ST_IDLE) && !(hold_req && !locked) && any_req)
      || ((state_reg == `EBHA_ST_BUSY) && i_cycle_done && locked);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         `EBHA_ST_RESET: begin
            state_next = warm_now ? `EBHA_ST_GAP : `EBHA_ST_IDLE;
         end
         `EBHA_ST_GAP: begin
            state_next = hold_req ? `EBHA_ST_HOLD : `EBHA_ST_IDLE;
         end
         `EBHA_ST_IDLE: begin
            if (hold_req && !locked) begin
               state_next = i_halt_mode ? `EBHA_ST_HOLD : `EBHA_ST_FLOAT;
            end else if (any_req) begin
               state_next = `EBHA_ST_BUSY;
            end
         end
         `EBHA_ST_BUSY: begin
            if (i_cycle_done && !locked) begin
               state_next = `EBHA_ST_IDLE;
            end
         end
         `EBHA_ST_FLOAT: begin
            state_next = hold_req ? `EBHA_ST_HOLD : `EBHA_ST_IDLE;
         end
         `EBHA_ST_HOLD: begin
            state_next = hold_req ? `EBHA_ST_HOLD : `EBHA_ST_IDLE;
         end
         default: begin
            state_next = `EBHA_ST_IDLE;
         end
      endcase
   end

   // A request held through power-on reset is blocked until the pin is seen high once.
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         por_block_reg <= 1'h0;
      end else if (state_reg == `EBHA_ST_RESET) begin
         por_block_reg <= i_power_on_rst & ~req_sync_reg[1];
      end else if (req_sync_reg[1]) begin
         por_block_reg <= 1'h0;
      end
   end

   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg <= `EBHA_ST_RESET;
         grant_reg <= 1'h0;
         float_reg <= 1'h0;
      end else begin
         state_reg <= state_next;
         grant_reg <= (state_next == `EBHA_ST_HOLD);
         float_reg <= (state_next == `EBHA_ST_HOLD) || (state_next == `EBHA_ST_FLOAT);
      end
   end

   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         piece_left_reg <= 3'h0;
         sizes_reg <= 6'h00;
         rmw_pend_reg <= 1'h0;
         o_owner <= `EBHA_REQ_NONE;
         o_piece_size <= `EBHA_SZ_BYTE;
         o_rmw_write <= 1'h0;
      end else if (start) begin
         o_owner <= pick;
         o_rmw_write <= 1'h0;
         if (pick == `EBHA_REQ_OPER) begin
            if (piece_left_reg != 3'h0) begin
               piece_left_reg <= piece_left_reg - 3'h1;
               o_piece_size <= sizes_reg[1:0];
               sizes_reg <= {2'h0, sizes_reg[5:2]};
            end else if (rmw_pend_reg) begin
               rmw_pend_reg <= 1'h0;
               o_rmw_write <= 1'h1;
               o_piece_size <= i_oper_size;
            end else begin
               piece_left_reg <= pieces - 3'h1;
               o_piece_size <= piece_sizes[1:0];
               sizes_reg <= {2'h0, piece_sizes[5:2]};
               rmw_pend_reg <= i_oper_rmw;
            end
         end else begin
            o_piece_size <= `EBHA_SZ_WORD;
         end
      end
   end

   assign o_cycle_start = start;
   // Operand request is consumed on its first piece; the rest runs from the lock.
   assign o_oper_ack = start && (pick == `EBHA_REQ_OPER) && !locked;
   assign o_ext_stall = (state_reg == `EBHA_ST_HOLD || state_reg == `EBHA_ST_FLOAT)
      && any_req;
   assign o_bus_hold_grant_n = ~grant_reg;
   assign o_bus_hold_grant_n_oe_n = ~hold_enabled;
   assign o_bus_float_n = ~float_reg;
endmodule
`default_nettype wire

// file: bench/ebha_chk.sv
// Port assertions for the external bus hold arbiter.
`timescale 1ns/1ns
`default_nettype none
module ebha_chk (
   input wire i_core_clk,
   input wire i_nrst,
   input wire i_bus_hold_request_n,
   input wire i_port_pin_grant_function,
   input wire i_port_pin_request_function,
   input wire i_stop_idle_mode,
   input wire i_halt_mode,
   input wire i_refresh_req,
   input wire i_cpu_bus_clk,
   input wire o_bus_hold_grant_n,
   input wire o_bus_float_n,
   input wire [2:0] o_owner,
   input wire o_cycle_start
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   chk_grant_floated: assert property (!o_bus_hold_grant_n |-> !o_bus_float_n)
      else $error("grant while bus driven");
   chk_pins_gate: assert property ($fell(o_bus_float_n) |->
      $past(i_port_pin_grant_function && i_port_pin_request_function)) else $error("pins off");
   chk_stop_gate: assert property ($fell(o_bus_float_n) |-> !$past(i_stop_idle_mode))
      else $error("hold in stop");
   chk_release_req: assert property (i_bus_hold_request_n [*5] |-> o_bus_hold_grant_n)
      else $error("grant kept");
   chk_grant_cause: assert property ($fell(o_bus_hold_grant_n) |->
      !$past(i_bus_hold_request_n, 3)) else $error("grant without request");
   chk_refresh_prio: assert property (o_cycle_start && i_refresh_req && !i_cpu_bus_clk
      |=> o_owner inside {3'h3, 3'h1}) else $error("refresh lost");
   chk_halt_grant: assert property ($fell(o_bus_float_n) && $past(i_halt_mode)
      |-> !o_bus_hold_grant_n) else $error("halt grant late");
   chk_hold_stall: assert property (!o_bus_hold_grant_n |-> !o_cycle_start)
      else $error("cycle during hold");
endmodule
bind ebha_arbiter ebha_chk ebha_chk_inst (.*);
`default_nettype wire

// file: bench/ebha_master.sv
// Outside bus master asking for the external bus.
`timescale 1ns/1ns
`default_nettype none
module ebha_master (
   input wire i_core_clk,
   input wire i_want,
   input wire i_quit,
   input wire i_grant_n,
   output logic o_req_n
);
   // A request stays low until granted unless it is withdrawn by i_quit.
   initial o_req_n = 1'b1;
   always @(posedge i_core_clk) begin
      o_req_n <= !(i_want || (!o_req_n && i_grant_n && !i_quit));
   end
endmodule
`default_nettype wire

// file: bench/ebha_arbiter_tb_top.sv
// Self-checking bench for the external bus hold arbiter.
`timescale 1ns/1ns
`default_nettype none
module ebha_arbiter_tb_top;
   logic i_core_clk=0, i_nrst=0, i_power_on_rst=1, i_port_pin_grant_function=1;
   logic i_port_pin_request_function=1, i_bus8=0, i_cpu_bus_clk=0, i_stop_idle_mode=0;
   logic i_halt_mode=0, i_refresh_req=0, i_dma_req=0, i_fetch_req=0, i_oper_req=0;
   logic i_oper_rmw=0, i_cycle_done=0, want=1, quit=0;
   logic [1:0] i_oper_size=0, i_oper_addr_low=0;
   logic [31:0] s=93;
   wire i_bus_hold_request_n, o_bus_hold_grant_n, o_bus_hold_grant_n_oe_n, o_bus_float_n;
   wire o_rmw_write, o_cycle_start, o_oper_ack, o_ext_stall;
   wire [2:0] o_owner;
   wire [1:0] o_piece_size;
   int err_total=0, comparisons=0, cyc=0, n, e, ns;
   ebha_arbiter ebha_arbiter_inst (.*);
   ebha_master ebha_master_inst (.i_core_clk(i_core_clk), .i_want(want), .i_quit(quit),
      .i_grant_n(o_bus_hold_grant_n), .o_req_n(i_bus_hold_request_n));
   always #25 i_core_clk = !i_core_clk;
   always @(posedge i_core_clk) if (o_cycle_start === 1'b1) ns++;
   always @(posedge i_core_clk) if (++cyc == 20000) begin err_total++; wrap_up; end
   function logic [31:0] xs(input logic [31:0] v);
      logic [31:0] a;
      a = v ^ (v << 13);
      a = a ^ (a >> 17);
      return a ^ (a << 5);
   endfunction
   function int pc(input logic b, input logic [1:0] z, input logic [1:0] a, input logic m);
      pc = (z == 2) ? (b ? 4 : (a[0] ? 3 : 2)) : (z == 1 && (b || a[0])) ? 2 : 1;
      if (m) pc = pc * 2;
   endfunction
   task chk(input string nm, input logic [3:0] ex, input logic [3:0] got);
      comparisons++;
      if (got !== ex) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task wg(input string nm, input logic lv);
      n = 0;
      while (o_bus_hold_grant_n !== lv && n < 12) begin @(negedge i_core_clk); n++; end
      chk(nm, lv, o_bus_hold_grant_n);
   endtask
   task op(input logic b, input logic [1:0] z, input logic [1:0] a, input logic m);
      i_bus8 = b; i_oper_size = z; i_oper_addr_low = a; i_oper_rmw = m; i_oper_req = 1;
      ns = 0;
      e = pc(b, z, a, m);
      @(negedge i_core_clk) i_oper_req = 0;
      want = 1;
      repeat (e) begin
         s = xs(s);
         repeat (s[1:0] + 1) @(negedge i_core_clk);
         chk("held", 1, o_bus_hold_grant_n);
         i_cycle_done = 1;
         @(negedge i_core_clk) i_cycle_done = 0;
      end
      chk("pieces", e, ns);
      wg("grant", 0);
      chk("float", 0, o_bus_float_n);
      i_fetch_req = 1;
      #1 chk("stall", 1, o_ext_stall);
      @(negedge i_core_clk) i_fetch_req = 0;
      want = 0;
      wg("free", 1);
   endtask
   task wrap_up;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge i_core_clk);
      i_nrst = 1;
      repeat (20) @(negedge i_core_clk);
      chk("por", 1, o_bus_hold_grant_n);
      quit = 1; want = 0;
      @(negedge i_core_clk) quit = 0;
      i_power_on_rst = 0; want = 1; i_nrst = 0;
      repeat (4) @(negedge i_core_clk);
      chk("rst", 1, o_bus_hold_grant_n);
      i_nrst = 1;
      @(negedge i_core_clk) chk("idle", 1, o_bus_hold_grant_n);
      @(negedge i_core_clk) chk("warm", 0, o_bus_hold_grant_n);
      want = 0;
      wg("free", 1);
      for (int k = 0; k < 3; k++) begin
         i_stop_idle_mode = (k == 0); i_port_pin_grant_function = (k != 1); i_halt_mode = (k == 2);
         want = 1;
         repeat (8) @(negedge i_core_clk);
         chk("gate", k != 2, o_bus_hold_grant_n);
         chk("oe", k == 1, o_bus_hold_grant_n_oe_n);
         want = 0; quit = 1;
         @(negedge i_core_clk) quit = 0;
         repeat (4) @(negedge i_core_clk);
         wg("free", 1);
         i_stop_idle_mode = 0; i_port_pin_grant_function = 1;
         i_halt_mode = 0;
      end
      for (int k = 0; k < 16; k++) op(k[3], {k[2], !k[2]}, k[1:0], 0);
      op(0, 0, 1, 1);
      i_oper_rmw = 0;
      repeat (40) begin
         @(negedge i_core_clk) s = xs(s);
         {i_refresh_req, i_dma_req, i_fetch_req, i_oper_req, i_cpu_bus_clk} = s[4:0];
         e = s[4] ? 3 : s[3] ? 2 : s[2] ? 0 : s[1] ? 1 : 7;
         #1 chk("start", e != 7, o_cycle_start);
         chk("ack", e == 1, o_oper_ack);
         @(posedge i_core_clk) #1;
         if (e != 7) begin
            chk("owner", e, o_owner);
            @(negedge i_core_clk) {i_refresh_req, i_dma_req, i_fetch_req, i_oper_req} = 0;
            i_cycle_done = 1;
            @(negedge i_core_clk) i_cycle_done = 0;
         end
      end
      wrap_up;
   end
endmodule
`default_nettype wire
